/* File: hdl/utr_transceiver.sv */
// Serial transceiver: transmit buffer and shifter, receiver with a two-entry
// buffer and per-entry error flags, registers on classic Wishbone.
// Assumes one clock; the serial pins and transfer clock are asynchronous.
`timescale 1ns/1ns
`include "utr_regs.svh"

// Notes on behaviour
// - Buffer-empty flag high exactly while buffer empty
// - Data write loads buffer, clears empty flag
// - Empty request held while flag and enable
// - Complete flag set after frame, buffer empty
// - Complete flag cleared by service or one-write
// - Complete request raised when flag and enable
// - Parity bit sent between data and stop
// - Transmit disable waits for shifter and buffer
// - Receive enable claims input; sync uses pin clock
// - Shift to first stop, ignore second, store
// - Unused upper data bits read as zero
// - Entries keep ninth bit and error flags
// - Receive flag means unread data; disable flushes
// - Receive request held while data unread
// - Error flags read only, never interrupt
// - Frame error shows first stop bit only
// - Overrun when full, held, new start
// - Checker compares parity, stores per entry
// - Parity error zero while checking disabled
// - Receive disable aborts frame, releases pin, flushes
// - Parity is data exclusive-or, inverted odd
// - Shifter loads when idle or after stop
// - Start low, data LSB first, stops high
module utr_transceiver (
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        serial_in_pin_i,
  input  wire logic        external_transfer_clock_pin_i,
  input  wire logic        tx_complete_irq_ack_i,
  output logic             serial_out_pin_o,
  output logic             serial_out_oe_o,
  output logic             serial_in_override_o,
  output logic             irq_tx_empty_o,
  output logic             irq_tx_complete_o,
  output logic             irq_rx_complete_o
);
  import utr_pkg::*;

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  function automatic logic [3:0] char_bits(input logic [2:0] code);
    if (code == `UTR_SIZE_NINE) begin
      char_bits = 4'h9;
    end else begin
      char_bits = 4'h5 + {2'h0, code[1:0]};
    end
  endfunction : char_bits

  function automatic logic [8:0] data_mask(input logic [3:0] n);
    data_mask = 9'h1ff >> (4'h9 - n);
  endfunction : data_mask

  function automatic logic parity_of(input logic [8:0] d, input logic [8:0] m,
                                     input logic odd);
    parity_of = (^(d & m)) ^ odd;
  endfunction : parity_of

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  logic [7:0]  ctrl_b_reg;
  logic [7:0]  ctrl_c_reg;
  logic [15:0] baud_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        access;
  logic        wr_data;
  logic        rd_data;
  logic        wr_stat;
  logic [3:0]  nbits;
  logic [8:0]  mask;
  logic        sync_mode;
  logic        parity_en;
  logic        rx_en;
  logic [2:0]  in_sync_reg;
  logic [2:0]  xck_sync_reg;
  logic        rx_line;
  logic        rx_prev;
  logic        xck_rise;
  logic        xck_fall;
  logic [8:0]  tx_buf_reg;
  logic        tx_buf_full_reg;
  logic        tx_active_reg;
  logic        tx_complete_reg;
  utr_tx_state_type tx_state_reg;
  logic [8:0]  tx_sh_reg;
  logic        tx_par_reg;
  logic [3:0]  tx_bit_reg;
  logic [15:0] tx_cnt_reg;
  logic        tx_tick;
  logic        tx_frame_end;
  logic        tx_load;
  utr_rx_state_type rx_state_reg;
  logic [8:0]  rx_sh_reg;
  logic        rx_par_reg;
  logic [3:0]  rx_bit_reg;
  logic [15:0] rx_cnt_reg;
  logic        rx_tick;
  logic        rx_start_ok;
  logic        rx_done;
  logic [8:0]  rx_aligned;
  logic [11:0] hold_reg;
  logic        hold_valid_reg;
  logic        lost_reg;
  logic [11:0] fifo_mem [0:1];
  logic        wp_reg;
  logic        rp_reg;
  logic [1:0]  count_reg;
  logic        push;
  logic        pop;
  logic [11:0] head;
  logic [7:0]  status_a;

  assign nbits     = char_bits({ctrl_b_reg[`UTR_CB_SZ2], ctrl_c_reg[`UTR_CC_SZ1],
                                ctrl_c_reg[`UTR_CC_SZ0]});
  assign mask      = data_mask(nbits);
  assign sync_mode = ctrl_c_reg[`UTR_CC_SYNC];
  assign parity_en = ctrl_c_reg[`UTR_CC_PEN];
  assign rx_en     = ctrl_b_reg[`UTR_CB_RXEN];

  // --------------------------------------------------------------------------
  // Wishbone slave: ack one cycle after request, commit at the ack edge
  // --------------------------------------------------------------------------
  assign access  = wb_cyc_i & wb_stb_i & ack_reg;
  assign wr_data = access & wb_we_i & wb_sel_i[0] & (wb_adr_i == `UTR_OFF_DATA);
  assign rd_data = access & ~wb_we_i & (wb_adr_i == `UTR_OFF_DATA);
  assign wr_stat = access & wb_we_i & wb_sel_i[0] & (wb_adr_i == `UTR_OFF_STATUS_A);

  assign head = (count_reg != 2'h0) ? fifo_mem[rp_reg] : 12'h0;
  assign status_a = {count_reg != 2'h0, tx_complete_reg, ~tx_buf_full_reg,
                     head[9], head[11], head[10] & parity_en, 2'h0};

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h0;
    end else begin
      ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
      if (wb_cyc_i & wb_stb_i & ~ack_reg & ~wb_we_i) begin
        case (wb_adr_i)
          `UTR_OFF_DATA:      dat_reg <= {24'h0, head[7:0]};
          `UTR_OFF_STATUS_A:  dat_reg <= {24'h0, status_a};
          `UTR_OFF_CONTROL_B: dat_reg <= {24'h0, ctrl_b_reg[7:2], head[8],
                                          ctrl_b_reg[0]};
          `UTR_OFF_CONTROL_C: dat_reg <= {24'h0, ctrl_c_reg};
          `UTR_OFF_BAUD:      dat_reg <= {16'h0, baud_reg};
          default:            dat_reg <= 32'h0;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;

  // Error flags have no storage here, so writes to them are dropped
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl_b_reg <= `UTR_CB_RESET;
      ctrl_c_reg <= `UTR_CC_RESET;
      baud_reg   <= `UTR_BAUD_RESET;
    end else if (access & wb_we_i) begin
      if (wb_sel_i[0] & (wb_adr_i == `UTR_OFF_CONTROL_B)) begin
        ctrl_b_reg <= {wb_dat_i[7:2], 1'b0, wb_dat_i[0]};
      end
      if (wb_sel_i[0] & (wb_adr_i == `UTR_OFF_CONTROL_C)) begin
        ctrl_c_reg <= {1'b0, wb_dat_i[6:1], 1'b0};
      end
      if (wb_adr_i == `UTR_OFF_BAUD) begin
        if (wb_sel_i[0]) begin
          baud_reg[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          baud_reg[15:8] <= wb_dat_i[15:8];
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // Pin synchronisers and transfer clock edges
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      in_sync_reg  <= 3'h7;
      xck_sync_reg <= 3'h0;
    end else begin
      in_sync_reg  <= {in_sync_reg[1:0], serial_in_pin_i};
      xck_sync_reg <= {xck_sync_reg[1:0], external_transfer_clock_pin_i};
    end
  end

  assign rx_line  = in_sync_reg[1];
  assign rx_prev  = in_sync_reg[2];
  assign xck_rise = xck_sync_reg[1] & ~xck_sync_reg[2];
  assign xck_fall = ~xck_sync_reg[1] & xck_sync_reg[2];

  // --------------------------------------------------------------------------
  // Transmit buffer and enable
  // --------------------------------------------------------------------------
  assign tx_tick = sync_mode ? xck_fall : (tx_cnt_reg == 16'h0);
  assign tx_frame_end = tx_tick & (((tx_state_reg == TX_STOP1) & ~ctrl_c_reg[`UTR_CC_STOP2])
                        | (tx_state_reg == TX_STOP2));
  assign tx_load = tx_buf_full_reg & tx_active_reg
                   & ((tx_state_reg == TX_IDLE) | tx_frame_end);

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_buf_full_reg <= 1'b0;
      tx_buf_reg      <= 9'h0;
    end else if (wr_data) begin
      tx_buf_full_reg <= 1'b1;
      tx_buf_reg      <= {ctrl_b_reg[`UTR_CB_TX9], wb_dat_i[7:0]};
    end else if (tx_load) begin
      tx_buf_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_active_reg <= 1'b0;
    end else if (ctrl_b_reg[`UTR_CB_TX_ON]) begin
      tx_active_reg <= 1'b1;
    end else if (~tx_buf_full_reg & (tx_state_reg == TX_IDLE)) begin
      tx_active_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Transmit shifter
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i | (tx_state_reg == TX_IDLE) | tx_load | (tx_cnt_reg == 16'h0)) begin
      tx_cnt_reg <= reset_i ? 16'h0 : baud_reg;
    end else begin
      tx_cnt_reg <= tx_cnt_reg - 16'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_state_reg     <= TX_IDLE;
      tx_sh_reg        <= 9'h0;
      tx_par_reg       <= 1'b0;
      tx_bit_reg       <= 4'h0;
      serial_out_pin_o <= 1'b1;
    end else if (tx_load) begin
      tx_state_reg     <= TX_START;
      tx_sh_reg        <= tx_buf_reg & mask;
      tx_par_reg       <= parity_of(tx_buf_reg, mask, ctrl_c_reg[`UTR_CC_PODD]);
      tx_bit_reg       <= 4'h0;
      serial_out_pin_o <= 1'b0;
    end else if (tx_tick) begin
      case (tx_state_reg)
        TX_START: begin
          tx_state_reg     <= TX_DATA;
          serial_out_pin_o <= tx_sh_reg[0];
          tx_sh_reg        <= {1'b0, tx_sh_reg[8:1]};
          tx_bit_reg       <= 4'h1;
        end
        TX_DATA: begin
          if (tx_bit_reg == nbits) begin
            tx_state_reg     <= parity_en ? TX_PARITY : TX_STOP1;
            serial_out_pin_o <= parity_en ? tx_par_reg : 1'b1;
          end else begin
            serial_out_pin_o <= tx_sh_reg[0];
            tx_sh_reg        <= {1'b0, tx_sh_reg[8:1]};
            tx_bit_reg       <= tx_bit_reg + 4'h1;
          end
        end
        TX_PARITY: begin
          tx_state_reg     <= TX_STOP1;
          serial_out_pin_o <= 1'b1;
        end
        TX_STOP1: begin
          tx_state_reg <= ctrl_c_reg[`UTR_CC_STOP2] ? TX_STOP2 : TX_IDLE;
        end
        TX_STOP2: begin
          tx_state_reg <= TX_IDLE;
        end
        default: begin
          tx_state_reg     <= TX_IDLE;
          serial_out_pin_o <= 1'b1;
        end
      endcase
    end
  end

  // Set wins over any clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      tx_complete_reg <= 1'b0;
    end else if (tx_frame_end & ~tx_buf_full_reg) begin
      tx_complete_reg <= 1'b1;
    end else if (tx_complete_irq_ack_i | (wr_stat & wb_dat_i[`UTR_SA_TXC])) begin
      tx_complete_reg <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Receiver
  // --------------------------------------------------------------------------
  assign rx_tick = sync_mode ? xck_rise : (rx_cnt_reg == 16'h0);
  assign rx_start_ok = sync_mode ? ((rx_state_reg == RX_IDLE) & xck_rise & ~rx_line)
                                 : ((rx_state_reg == RX_START) & rx_tick & ~rx_line);
  assign rx_done = rx_tick & (rx_state_reg == RX_STOP);
  assign rx_aligned = (rx_sh_reg >> (4'h9 - nbits)) & mask;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rx_cnt_reg <= 16'h0;
    end else if ((rx_state_reg == RX_IDLE) | (rx_cnt_reg == 16'h0)) begin
      rx_cnt_reg <= (rx_state_reg == RX_IDLE) ? {1'b0, baud_reg[15:1]} : baud_reg;
    end else begin
      rx_cnt_reg <= rx_cnt_reg - 16'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i | ~rx_en) begin
      rx_state_reg <= RX_IDLE;
      rx_sh_reg    <= 9'h0;
      rx_par_reg   <= 1'b0;
      rx_bit_reg   <= 4'h0;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          if (rx_start_ok) begin
            rx_state_reg <= RX_DATA;
          end else if (~sync_mode & rx_prev & ~rx_line) begin
            rx_state_reg <= RX_START;
          end
          rx_bit_reg <= 4'h0;
        end
        RX_START: begin
          if (rx_tick) begin
            rx_state_reg <= rx_line ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          if (rx_tick) begin
            rx_sh_reg  <= {rx_line, rx_sh_reg[8:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == nbits - 4'h1) begin
              rx_state_reg <= parity_en ? RX_PARITY : RX_STOP;
            end
          end
        end
        RX_PARITY: begin
          if (rx_tick) begin
            rx_par_reg   <= rx_line;
            rx_state_reg <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_state_reg <= RX_IDLE;
          end
        end
        default: begin
          rx_state_reg <= RX_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Holding stage, overrun and two-entry buffer
  // --------------------------------------------------------------------------
  assign push = hold_valid_reg & (count_reg != `UTR_FIFO_DEPTH);
  assign pop  = rd_data & (count_reg != 2'h0);

  // Entry layout: overrun, parity error, frame error, nine data bits
  always_ff @(posedge ref_clk_i) begin
    if (reset_i | ~rx_en) begin
      hold_valid_reg <= 1'b0;
      hold_reg       <= 12'h0;
    end else if (rx_done) begin
      hold_valid_reg <= 1'b1;
      hold_reg       <= {1'b0,
                         parity_en & (parity_of(rx_aligned, mask,
                                      ctrl_c_reg[`UTR_CC_PODD]) != rx_par_reg),
                         ~rx_line, rx_aligned};
    end else if (push) begin
      hold_valid_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i | ~rx_en) begin
      lost_reg <= 1'b0;
    end else if (rx_start_ok & hold_valid_reg & ~push) begin
      lost_reg <= 1'b1;
    end else if (push) begin
      lost_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      fifo_mem[0] <= 12'h0;
      fifo_mem[1] <= 12'h0;
    end else if (push) begin
      fifo_mem[wp_reg] <= {lost_reg, hold_reg[10:0]};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i | ~rx_en) begin
      wp_reg    <= 1'b0;
      rp_reg    <= 1'b0;
      count_reg <= 2'h0;
    end else begin
      wp_reg    <= wp_reg ^ push;
      rp_reg    <= rp_reg ^ pop;
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // --------------------------------------------------------------------------
  // Pin control and interrupt requests
  // --------------------------------------------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      serial_out_oe_o      <= 1'b0;
      serial_in_override_o <= 1'b0;
      irq_tx_empty_o       <= 1'b0;
      irq_tx_complete_o    <= 1'b0;
      irq_rx_complete_o    <= 1'b0;
    end else begin
      serial_out_oe_o      <= tx_active_reg;
      serial_in_override_o <= rx_en;
      irq_tx_empty_o       <= ~tx_buf_full_reg & ctrl_b_reg[`UTR_CB_UDRIE];
      irq_tx_complete_o    <= tx_complete_reg & ctrl_b_reg[`UTR_CB_TXCIE];
      irq_rx_complete_o    <= (count_reg != 2'h0) & ctrl_b_reg[`UTR_CB_RXC_IRQ];
    end
  end

endmodule : utr_transceiver

/* File: hdl/utr_regs.svh */
// Register map, field positions, reset values and timing of the serial transceiver.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
`ifndef UTR_REGS_SVH
`define UTR_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define UTR_OFF_DATA      8'h00
`define UTR_OFF_STATUS_A  8'h04
`define UTR_OFF_CONTROL_B 8'h08
`define UTR_OFF_CONTROL_C 8'h0c
`define UTR_OFF_BAUD      8'h10

// ----------------------------------------------------------------------------
// Status register a fields
// ----------------------------------------------------------------------------
`define UTR_SA_RXC   7
`define UTR_SA_TXC   6
`define UTR_SA_UDRE  5
`define UTR_SA_FE    4
`define UTR_SA_DOR   3
`define UTR_SA_PE    2

// ----------------------------------------------------------------------------
// Control register b fields
// ----------------------------------------------------------------------------
`define UTR_CB_RXC_IRQ 7
`define UTR_CB_TXCIE 6
`define UTR_CB_UDRIE 5
`define UTR_CB_RXEN  4
`define UTR_CB_TX_ON 3
`define UTR_CB_SZ2   2
`define UTR_CB_RX9   1
`define UTR_CB_TX9   0

// ----------------------------------------------------------------------------
// Control register c fields
// ----------------------------------------------------------------------------
`define UTR_CC_SYNC  6
`define UTR_CC_PEN   5
`define UTR_CC_PODD  4
`define UTR_CC_STOP2 3
`define UTR_CC_SZ1   2
`define UTR_CC_SZ0   1

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define UTR_CB_RESET   8'h00
`define UTR_CC_RESET   8'h06
`define UTR_BAUD_RESET 16'h000f
`define UTR_SIZE_NINE  3'h7
`define UTR_FIFO_DEPTH 2'h2

`endif

/* File: hdl/utr_pkg.sv */
// Types shared by the serial transceiver.
// Assumes utr_regs.svh carries the numeric constants.
package utr_pkg;

  // Gray codes along the normal frame path
  typedef enum logic [2:0] {
    TX_IDLE   = 3'h0,
    TX_START  = 3'h1,
    TX_DATA   = 3'h3,
    TX_PARITY = 3'h2,
    TX_STOP1  = 3'h6,
    TX_STOP2  = 3'h7
  } utr_tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'h0,
    RX_START  = 3'h1,
    RX_DATA   = 3'h3,
    RX_PARITY = 3'h2,
    RX_STOP   = 3'h6
  } utr_rx_state_type;

endpackage : utr_pkg

/* File: tb/utr_transceiver_properties.sv */
// Checker on the transceiver ports, bound to every instance.
// Assumes at least four clocks per serial bit.
`timescale 1ns/1ns
module utr_transceiver_properties (
  input logic ref_clk_i,
  input logic reset_i,
  input logic wb_cyc_i,
  input logic tx_complete_irq_ack_i,
  input logic serial_out_pin_o,
  input logic serial_out_oe_o,
  input logic serial_in_override_o,
  input logic irq_tx_empty_o,
  input logic irq_tx_complete_o,
  input logic irq_rx_complete_o
);
  // ----
  // Sequences and properties
  // ----
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_quiet_bus;
    !wb_cyc_i && !$past(wb_cyc_i);
  endsequence
  sequence s_low_bit;
    !serial_out_pin_o [*4];
  endsequence
  AST_TXE_IRQ_HOLD: assert property (
    irq_tx_empty_o ##0 s_quiet_bus |=> irq_tx_empty_o) else $error("empty request lost");
  AST_RXC_IRQ_HOLD: assert property (
    irq_rx_complete_o ##0 s_quiet_bus |=> irq_rx_complete_o) else $error("rx request lost");
  AST_RXC_NEEDS_RX: assert property (
    $rose(irq_rx_complete_o) |-> serial_in_override_o) else $error("rx request while off");
  AST_RX_OFF_QUIET: assert property (
    !serial_in_override_o [*3] |-> !irq_rx_complete_o) else $error("rx data kept when off");
  AST_LOW_BIT_LEN: assert property (
    $fell(serial_out_pin_o) |-> s_low_bit) else $error("short low bit");
  AST_LOW_DRIVEN: assert property (
    !serial_out_pin_o |-> serial_out_oe_o) else $error("low line not driven");
  AST_TXC_ACK_CLR: assert property (
    tx_complete_irq_ack_i && serial_out_pin_o |-> ##2 !irq_tx_complete_o)
    else $error("complete not cleared by service");
  AST_TXC_AFTER_STOP: assert property (
    $rose(irq_tx_complete_o) |-> $past(serial_out_pin_o, 4)) else $error("early complete");
endmodule : utr_transceiver_properties

bind utr_transceiver utr_transceiver_properties u_props (
  .ref_clk_i(ref_clk_i), .reset_i(reset_i), .wb_cyc_i(wb_cyc_i),
  .tx_complete_irq_ack_i(tx_complete_irq_ack_i), .serial_out_pin_o(serial_out_pin_o),
  .serial_out_oe_o(serial_out_oe_o), .serial_in_override_o(serial_in_override_o),
  .irq_tx_empty_o(irq_tx_empty_o), .irq_tx_complete_o(irq_tx_complete_o),
  .irq_rx_complete_o(irq_rx_complete_o));

/* File: tb/utr_remote_node.sv */
// Remote node: sends one frame per request; the line idles high.
// Assumes send_i is a one-clock pulse while busy_o is low.
`timescale 1ns/1ns
module utr_remote_node #(
  parameter int BIT_CYCLES = 4
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        send_i,
  input  wire logic [10:0] frame_i,
  output logic             line_o,
  output logic             busy_o
);
  logic [11:0] shift_reg;
  logic [3:0]  bits_reg;
  int          tick_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_o <= 1'b0;
    end else if (send_i && !busy_o) begin
      shift_reg <= {frame_i, 1'b0};
      bits_reg  <= 4'hc;
      tick_reg  <= 0;
      busy_o    <= 1'b1;
    end else if (busy_o && tick_reg == BIT_CYCLES - 1) begin
      tick_reg  <= 0;
      shift_reg <= {1'b1, shift_reg[11:1]};
      bits_reg  <= bits_reg - 4'h1;
      busy_o    <= bits_reg != 4'h1;
    end else if (busy_o) begin
      tick_reg <= tick_reg + 1;
    end
  end
  assign line_o = busy_o ? shift_reg[0] : 1'b1;
endmodule : utr_remote_node

/* File: tb/test_utr_transceiver.sv */
// Bench: reset rows, frames out and in, error flags, disables.
// Assumes the remote node model and the bound checker.
`timescale 1ns/1ns
module test_utr_transceiver;
  typedef struct {logic [7:0] a; logic [31:0] e;} utr_row_type;
  logic        clk, ack, sout, oe, ovr, ite, itc, irc, rin, busy;
  logic        rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, go = 1'b0, txc_ack = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [10:0] frm = '1, g;
  logic [31:0] dat = 32'h0, q, rdat;
  int          miscompares, n_tests;
  utr_row_type rows [5] = '{'{8'h04, 32'h20}, '{8'h08, 32'h00}, '{8'h0c, 32'h06},
                            '{8'h10, 32'h0f}, '{8'h14, 32'h00}};
  utr_transceiver u_dut (
    .ref_clk_i(clk), .reset_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .serial_in_pin_i(rin), .external_transfer_clock_pin_i(1'b0),
    .tx_complete_irq_ack_i(txc_ack), .serial_out_pin_o(sout), .serial_out_oe_o(oe),
    .serial_in_override_o(ovr), .irq_tx_empty_o(ite), .irq_tx_complete_o(itc),
    .irq_rx_complete_o(irc));
  utr_remote_node #(.BIT_CYCLES(4)) u_node (
    .clk_i(clk), .rst_i(rst), .send_i(go), .frame_i(frm), .line_o(rin), .busy_o(busy));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----
  // Tasks
  // ----
  task finish_test;
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] v);
    n_tests++;
    if (v !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, v);
    end
  endtask : chk
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task rd(input string n, input logic [7:0] a, input logic [31:0] e);
    bus(a, 1'b0, 32'h0);
    chk(n, e, q);
  endtask : rd
  task cap(output logic [10:0] b);
    b = '0;
    do @(posedge clk); while (sout !== 1'b1);
    do @(posedge clk); while (sout !== 1'b0);
    @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      repeat (4) @(posedge clk);
      b[i] = sout;
    end
  endtask : cap
  task send(input logic [10:0] f);
    @(posedge clk);
    frm <= f;
    go  <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    do @(posedge clk); while (busy === 1'b1);
    repeat (4) @(posedge clk);
  endtask : send
  // ----
  // Main sequence
  // ----
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) rd("reg", rows[i].a, rows[i].e);
    chk("pins", 32'h1, {ite, itc, irc, oe, sout});
    bus(8'h14, 1'b1, 32'h5a);
    rd("unmapped", 8'h14, 32'h0);
    bus(8'h10, 1'b1, 32'h3);
    bus(8'h0c, 1'b1, 32'h26);
    bus(8'h08, 1'b1, 32'h78);
    fork
      begin
        cap(g);
        chk("frame1", {1'b1, ^8'ha5, 8'ha5}, g);
        cap(g);
        chk("frame2", {1'b1, ^8'h3c, 8'h3c}, g);
      end
      begin
        bus(8'h00, 1'b1, 32'ha5);
        bus(8'h00, 1'b1, 32'h3c);
      end
    join
    chk("empty irq", 32'h1, ite);
    chk("override", 32'h1, ovr);
    do @(posedge clk); while (itc !== 1'b1);
    rd("txc set", 8'h04, 32'h60);
    bus(8'h04, 1'b1, 32'h0);
    rd("txc kept", 8'h04, 32'h60);
    bus(8'h04, 1'b1, 32'h40);
    rd("txc clr", 8'h04, 32'h20);
    chk("txc irq", 32'h0, itc);
    bus(8'h0c, 1'b1, 32'h36);
    fork
      begin
        cap(g);
        chk("frame3", {1'b1, ~^8'h03, 8'h03}, g);
      end
      begin
        bus(8'h00, 1'b1, 32'h03);
        bus(8'h08, 1'b1, 32'h50);
        chk("oe held", 32'h1, oe);
      end
    join
    do @(posedge clk); while (itc !== 1'b1);
    txc_ack <= 1'b1;
    @(posedge clk);
    txc_ack <= 1'b0;
    repeat (3) @(posedge clk);
    chk("txc ack", 32'h0, itc);
    chk("released", 32'h0, oe);
    chk("empty off", 32'h0, ite);
    bus(8'h08, 1'b1, 32'hd0);
    send({2'b11, ~^8'h5a, 8'h5a});
    chk("rx irq", 32'h1, irc);
    send({2'b11, ^8'h81, 8'h81});
    send({2'b11, 1'b1, 8'h00});
    send({2'b10, ~^8'h33, 8'h33});
    rd("st1", 8'h04, 32'ha0);
    rd("d1", 8'h00, 32'h5a);
    bus(8'h0c, 1'b1, 32'h06);
    rd("pe off", 8'h04, 32'ha0);
    bus(8'h0c, 1'b1, 32'h36);
    rd("st2", 8'h04, 32'ha4);
    rd("d2", 8'h00, 32'h81);
    rd("st3", 8'h04, 32'hb8);
    bus(8'h04, 1'b1, 32'h1c);
    rd("err kept", 8'h04, 32'hb8);
    rd("d3", 8'h00, 32'h33);
    rd("st4", 8'h04, 32'h20);
    chk("rx irq off", 32'h0, irc);
    bus(8'h0c, 1'b1, 32'h30);
    send({4'hf, 1'b1, ~^5'h1f, 5'h1f});
    rd("st5", 8'h04, 32'ha0);
    fork
      send({4'hf, 1'b1, 1'b0, 5'h0a});
      begin
        repeat (20) @(posedge clk);
        bus(8'h08, 1'b1, 32'h40);
      end
    join
    chk("ovr off", 32'h0, ovr);
    rd("flushed", 8'h04, 32'h20);
    bus(8'h08, 1'b1, 32'h50);
    rd("discard", 8'h04, 32'h20);
    send({4'hf, 1'b1, ~^5'h1f, 5'h1f});
    rd("d5", 8'h00, 32'h1f);
    bus(8'h0c, 1'b1, 32'h06);
    bus(8'h08, 1'b1, 32'h14);
    send({2'b11, 9'h1a5});
    rd("ninth", 8'h08, 32'h16);
    rd("d6", 8'h00, 32'ha5);
    finish_test;
  end
  initial begin
    repeat (6000) @(posedge clk);
    miscompares++;
    finish_test;
  end
endmodule : test_utr_transceiver
